/* File: verilog/suvm_pkg.sv */
// Constants for the supply undervoltage fault monitor.
// Assumes a single 40 MHz device clock.
package suvm_pkg;
	// ==========================================================
	// Input indication positions
	localparam int SUVM_IDX_MOTOR = 0;
	localparam int SUVM_IDX_DRAIN = 1;
	localparam int SUVM_IDX_PUMP = 2;
	localparam int SUVM_IDX_GLS = 3;
	localparam int SUVM_NUM_IND = 4;
	// ==========================================================
	// Reset values and synchroniser depth
	localparam logic SUVM_FLAG_RST = 1'h0;
	localparam logic SUVM_FAULT_N_RST = 1'h0;
	localparam int SUVM_SYNC_STAGES = 2;
	// ==========================================================
	// Monitor states
	typedef enum logic [1:0] {
		SUVM_ST_RUN,
		SUVM_ST_SUPPLY_LOW,
		SUVM_ST_GATE_LOW
	} suvm_state_t;
endpackage

/* File: verilog/suvm_sync.sv */
// Two-flop synchroniser for a bank of asynchronous level inputs.
// Assumes the inputs are slow comparator levels.
`timescale 1ns/1ps
module suvm_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	// ==========================================================
	// Next values: first stage read only by second
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// Register both stages
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;
endmodule // suvm_sync

/* File: verilog/suvm_monitor.sv */
// Supply undervoltage fault monitor: gate disable, pump stop, fault pin, sticky flags.
// Assumes comparator indications are asynchronous, active high, and that
// clear_faults_cmd_in and enable_reset_in are one-cycle pulses on sys_clk_in.
`timescale 1ns/1ps
module suvm_monitor
	import suvm_pkg::*;
#(
	parameter bit SERIAL_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Comparator indications, asynchronous
	input wire logic motor_supply_low_in,
	input wire logic drain_sense_supply_low_in,
	input wire logic high_side_pump_supply_low_in,
	input wire logic low_side_gate_supply_low_in,
	// Controller commands
	input wire logic clear_faults_cmd_in,
	input wire logic enable_reset_in,
	input wire logic gate_supply_check_off_in,
	// Protective actions
	output logic gate_enable_out,
	output logic pump_enable_out,
	output logic fault_out_n_out,
	// Status
	output logic global_fault_out,
	output logic supply_low_flag_out,
	output logic gate_supply_low_flag_out
);
	logic [SUVM_NUM_IND-1:0] raw_ind;
	logic [SUVM_NUM_IND-1:0] ind;
	logic supply_low;
	logic gate_low;
	logic gate_check_off;
	logic clr;
	suvm_state_t state_r;
	suvm_state_t state_nxt;
	logic global_r;
	logic global_nxt;
	logic supply_flag_r;
	logic supply_flag_nxt;
	logic gate_flag_r;
	logic gate_flag_nxt;
	logic gate_en_r;
	logic gate_en_nxt;
	logic pump_en_r;
	logic pump_en_nxt;
	logic fault_n_r;
	logic fault_n_nxt;

	// ==========================================================
	// Input synchronisation
	assign raw_ind[SUVM_IDX_MOTOR] = motor_supply_low_in;
	assign raw_ind[SUVM_IDX_DRAIN] = drain_sense_supply_low_in;
	assign raw_ind[SUVM_IDX_PUMP] = high_side_pump_supply_low_in;
	assign raw_ind[SUVM_IDX_GLS] = low_side_gate_supply_low_in;

	// Two flops before any fault logic looks at the comparators
	suvm_sync #(.WIDTH(SUVM_NUM_IND)) u_sync (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.async_in(raw_ind),
		.sync_out(ind)
	);

	// ==========================================================
	// Fault qualification
	// Disable bit only honoured on the serial variant
	assign gate_check_off = SERIAL_VARIANT & gate_supply_check_off_in;
	assign supply_low = ind[SUVM_IDX_MOTOR] | ind[SUVM_IDX_DRAIN];
	assign gate_low = (ind[SUVM_IDX_PUMP] | ind[SUVM_IDX_GLS]) & ~gate_check_off;
	assign clr = clear_faults_cmd_in | enable_reset_in;

	// ==========================================================
	// State and actions. A supply fault takes precedence because it must also stop
	// the pump; a gate supply fault on its own leaves the pump running.
	always_comb begin
		state_nxt = SUVM_ST_RUN;
		if (supply_low) begin
			state_nxt = SUVM_ST_SUPPLY_LOW;
		end else if (gate_low) begin
			state_nxt = SUVM_ST_GATE_LOW;
		end
		gate_en_nxt = 1'b0;
		pump_en_nxt = 1'b0;
		fault_n_nxt = 1'b0;
		case (state_nxt)
			SUVM_ST_RUN: begin
				gate_en_nxt = 1'b1;
				pump_en_nxt = 1'b1;
				fault_n_nxt = 1'b1;
			end
			SUVM_ST_SUPPLY_LOW: begin
				pump_en_nxt = 1'b0;
			end
			SUVM_ST_GATE_LOW: begin
				pump_en_nxt = 1'b1;
			end
			default: begin
				pump_en_nxt = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Sticky flags; a set in the clear cycle wins
	always_comb begin
		supply_flag_nxt = SERIAL_VARIANT & (supply_low | (supply_flag_r & ~clr));
		gate_flag_nxt = SERIAL_VARIANT & (gate_low | (gate_flag_r & ~clr));
		global_nxt = SERIAL_VARIANT & (supply_low | gate_low | (global_r & ~clr));
	end

	// Register state, actions and flags
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= SUVM_ST_RUN;
			gate_en_r <= 1'b0;
			pump_en_r <= 1'b0;
			fault_n_r <= SUVM_FAULT_N_RST;
			supply_flag_r <= SUVM_FLAG_RST;
			gate_flag_r <= SUVM_FLAG_RST;
			global_r <= SUVM_FLAG_RST;
		end else begin
			state_r <= state_nxt;
			gate_en_r <= gate_en_nxt;
			pump_en_r <= pump_en_nxt;
			fault_n_r <= fault_n_nxt;
			supply_flag_r <= supply_flag_nxt;
			gate_flag_r <= gate_flag_nxt;
			global_r <= global_nxt;
		end
	end

	assign gate_enable_out = gate_en_r;
	assign pump_enable_out = pump_en_r;
	assign fault_out_n_out = fault_n_r;
	assign global_fault_out = global_r;
	assign supply_low_flag_out = supply_flag_r;
	assign gate_supply_low_flag_out = gate_flag_r;

	// ==========================================================
	// Checks: one edge from synchronised level to registered response
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	// Motor or drain supply low
	supply_trip_a: assert property (supply_low |=>
		!gate_en_r && !pump_en_r && !fault_n_r)
		else $error("supply low did not shut gates and pump");
	supply_state_a: assert property (supply_low |=> state_r == SUVM_ST_SUPPLY_LOW)
		else $error("supply fault lost precedence");
	supply_flag_a: assert property (SERIAL_VARIANT && supply_low |=>
		supply_flag_r && global_r)
		else $error("supply flags not set");
	resume_a: assert property (!supply_low && !gate_low |=>
		gate_en_r && pump_en_r && fault_n_r)
		else $error("no resume after recovery");
	supply_hold_a: assert property (supply_flag_r && !clr |=> supply_flag_r)
		else $error("supply flag dropped without clear");
	supply_clear_a: assert property (clr && !supply_low |=> !supply_flag_r)
		else $error("supply flag survived a clear");

	// Pump or low-side regulator low
	gate_trip_a: assert property (gate_low && !supply_low |=>
		!gate_en_r && pump_en_r && !fault_n_r)
		else $error("gate supply low response wrong");
	gate_flag_a: assert property (SERIAL_VARIANT && gate_low |=>
		gate_flag_r && global_r)
		else $error("gate flags not set");
	gate_resume_a: assert property ($fell(gate_low) && !supply_low |=>
		gate_en_r && fault_n_r)
		else $error("no auto resume after gate recovery");
	gate_hold_a: assert property (gate_flag_r && !clr |=> gate_flag_r)
		else $error("gate flag dropped without clear");
	gate_clear_a: assert property (clr && !gate_low |=> !gate_flag_r)
		else $error("gate flag survived a clear");

	// Disable bit and the two variants
	check_off_a: assert property (gate_check_off && !supply_low |=> fault_n_r)
		else $error("gate fault acted while disabled");
	pin_guard_a: assert property (!SERIAL_VARIANT && !supply_low &&
		(ind[SUVM_IDX_PUMP] || ind[SUVM_IDX_GLS]) |=> !gate_en_r && !fault_n_r)
		else $error("pin variant gate protection was disabled");
	pin_flags_a: assert property (!SERIAL_VARIANT |->
		!global_r && !supply_flag_r && !gate_flag_r)
		else $error("pin variant set a status flag");
	both_flags_a: assert property (SERIAL_VARIANT && supply_low && gate_low |=>
		supply_flag_r && gate_flag_r)
		else $error("joint fault not recorded");

	// Global fault and clear
	global_keep_a: assert property (clr && (supply_low || gate_low) |=>
		global_r || !SERIAL_VARIANT)
		else $error("global fault cleared while active");
	global_clear_a: assert property (clr && !supply_low && !gate_low |=> !global_r)
		else $error("global fault survived a clear");

	// Synchroniser: fault logic sees the comparators two edges late, once out of reset
	sync_delay_a: assert property ($past(nrst_in) && $past(nrst_in, 2) |->
		ind == $past(raw_ind, 2))
		else $error("indication not delayed by two flops");

	// Main scenarios
	trip_c: cover property (supply_low ##1 !supply_low [*3] ##1 clr);
	gate_c: cover property (gate_low && supply_low);
	clear_c: cover property (global_r ##1 !global_r);
	off_c: cover property (gate_check_off && ind[SUVM_IDX_GLS] && !supply_low);
	resume_c: cover property (gate_low ##1 !gate_low [*3] ##1 gate_en_r);
endmodule // suvm_monitor

/* File: verif/suvm_ctrl.sv */
// Controller model: clear pulses and the gate supply check disable.
// Assumes the bench calls its tasks; signals move 1 ns after a rising edge.
`timescale 1ns/1ps
module suvm_ctrl (
	// Clock
	input wire logic sys_clk_in,
	// Commands
	output logic clear_faults_cmd_out,
	output logic enable_reset_out,
	output logic gate_supply_check_off_out
);
	// ==========================================================
	// Idle levels at time zero
	initial begin
		clear_faults_cmd_out = 1'h0;
		enable_reset_out = 1'h0;
		gate_supply_check_off_out = 1'h0;
	end
	// One-cycle clear, by command or by enable reset pulse
	task automatic pulse(input bit by_enable);
		@(posedge sys_clk_in) #1;
		if (by_enable)
			enable_reset_out = 1'h1;
		else
			clear_faults_cmd_out = 1'h1;
		@(posedge sys_clk_in) #1;
		enable_reset_out = 1'h0;
		clear_faults_cmd_out = 1'h0;
	endtask
	// Level that masks gate supply faults
	task automatic check_off(input logic v);
		@(posedge sys_clk_in) #1;
		gate_supply_check_off_out = v;
	endtask
endmodule // suvm_ctrl

/* File: verif/suvm_monitor_bench.sv */
// Bench for the supply undervoltage fault monitor.
// Assumes 3 cycles from comparator change to outputs, clear seen in 1.
`timescale 1ns/1ps
module suvm_monitor_bench;
	// ==========================================================
	// Signals
	logic clk;
	logic nrst;
	logic [3:0] ind;
	logic clr, rst_p, off, g, p, fn, gf, sf, gsf;
	logic pg, pp, pfn, pgf, psf, pgsf;
	int mismatches = 0;
	int compares = 0;
	// Clock, 25 ns period
	initial clk = 1'h0;
	always #12.5 clk = ~clk;
	// ==========================================================
	// Design and controller
	suvm_monitor dut (.sys_clk_in(clk), .nrst_in(nrst),
		.motor_supply_low_in(ind[0]), .drain_sense_supply_low_in(ind[1]),
		.high_side_pump_supply_low_in(ind[2]), .low_side_gate_supply_low_in(ind[3]),
		.clear_faults_cmd_in(clr), .enable_reset_in(rst_p), .gate_supply_check_off_in(off),
		.gate_enable_out(g), .pump_enable_out(p), .fault_out_n_out(fn),
		.global_fault_out(gf), .supply_low_flag_out(sf), .gate_supply_low_flag_out(gsf));
	suvm_ctrl ctrl (.sys_clk_in(clk), .clear_faults_cmd_out(clr),
		.enable_reset_out(rst_p), .gate_supply_check_off_out(off));
	// Pin variant on the same inputs; its disable input must have no effect
	suvm_monitor #(.SERIAL_VARIANT(1'b0)) dut_pin (.sys_clk_in(clk), .nrst_in(nrst),
		.motor_supply_low_in(ind[0]), .drain_sense_supply_low_in(ind[1]),
		.high_side_pump_supply_low_in(ind[2]), .low_side_gate_supply_low_in(ind[3]),
		.clear_faults_cmd_in(clr), .enable_reset_in(rst_p), .gate_supply_check_off_in(off),
		.gate_enable_out(pg), .pump_enable_out(pp), .fault_out_n_out(pfn),
		.global_fault_out(pgf), .supply_low_flag_out(psf), .gate_supply_low_flag_out(pgsf));
	// ==========================================================
	// Tasks
	// Set comparator levels and wait out the fixed latency
	task automatic step(input logic [3:0] v);
		@(posedge clk) #1;
		ind = v;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Compare {gate, pump, fault_n, global, supply, gate supply}
	task automatic chk(input logic [5:0] exp);
		compares++;
		if ({g, p, fn, gf, sf, gsf} !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, {g, p, fn, gf, sf, gsf}, exp);
		end
	endtask
	// Compare the pin variant's outputs, same bit order
	task automatic chk_pin(input logic [5:0] exp);
		compares++;
		if ({pg, pp, pfn, pgf, psf, pgsf} !== exp) begin
			mismatches++;
			$display("BAD t=%0t pin got=%h exp=%h", $time, {pg, pp, pfn, pgf, psf, pgsf}, exp);
		end
	endtask
	// Verdict and end of run
	task automatic test_done;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#20000;
		mismatches++;
		test_done;
	end
	// ==========================================================
	// Test sequence
	initial begin
		nrst = 1'h0;
		ind = 4'h0;
		repeat (3) @(posedge clk);
		#1;
		nrst = 1'h1;
		step(4'h0);
		chk(6'h38);
		chk_pin(6'h38);
		step(4'h1);
		chk(6'h06);
		chk_pin(6'h00);
		step(4'h0);
		chk(6'h3e);
		ctrl.pulse(0);
		chk(6'h38);
		step(4'h4);
		chk(6'h15);
		chk_pin(6'h10);
		step(4'h0);
		chk(6'h3d);
		ctrl.pulse(1);
		chk(6'h38);
		step(4'ha);
		chk(6'h07);
		ctrl.pulse(0);
		chk(6'h07);
		step(4'h0);
		chk(6'h3f);
		ctrl.pulse(1);
		chk(6'h38);
		ctrl.check_off(1'h1);
		step(4'h8);
		chk(6'h38);
		chk_pin(6'h10);
		step(4'h9);
		chk(6'h06);
		step(4'h0);
		ctrl.pulse(0);
		chk(6'h38);
		ctrl.check_off(1'h0);
		step(4'h8);
		chk(6'h15);
		// Mid-run reset with the gate indication still low
		@(posedge clk) #1;
		nrst = 1'h0;
		@(posedge clk) #1;
		nrst = 1'h1;
		@(posedge clk) #1;
		chk(6'h38);
		chk_pin(6'h38);
		repeat (2) @(posedge clk);
		#1;
		chk(6'h15);
		chk_pin(6'h10);
		test_done;
	end
endmodule // suvm_monitor_bench
